// file: dv/lsd_load_store_tb.sv
/*
 * Self-checking bench of the load/store decoder over APB.
 * Assumes the memory model answers every byte access without wait states.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lsd_map.vh"
module lsd_load_store_tb;
	localparam int         DMAP [4] = '{0, 1, 2, 10};
	localparam logic [7:0] BYTES [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h00, 8'h00, 8'h05};
	localparam logic [15:0] VEC [8] = '{0, 0, 16'h20, 16'h30, 16'h40, 16'h50, 0, 16'h70};
	logic        mclk, rst_n, psel, penable, pwrite, ev;
	logic [11:0] paddr;
	logic [31:0] pwdata, rv;
	wire  [31:0] prdata;
	wire         pready, pslverr, memReq, memWrite, busy;
	wire  [15:0] memAddr;
	wire  [7:0]  memWdata, memRdata;
	wire  [1:0]  memSpace;
	int          err_total, cmp_count, cyc;
	lsd_load_store u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
		.memWdata(memWdata), .memSpace(memSpace), .memRdata(memRdata), .busy(busy));
	lsd_mem_model u_mem (.mclk(mclk), .memReq(memReq), .memWrite(memWrite),
		.memAddr(memAddr), .memWdata(memWdata), .memSpace(memSpace), .memRdata(memRdata));
	always #4 mclk = ~mclk;
	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			err_total++;
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	function automatic logic [11:0] pa(input int i);
		return `LSD_OFF_PAIR + 12'(4 * i);
	endfunction
	// n is the expected busy length; zero means the command must be refused
	task automatic run(input logic [31:0] c, input logic [3:0] n);
		int k;
		wr(`LSD_OFF_CMD, c);
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (busy === 1'b1 && k < 40);
		chk(k - 1, n);
		apb(1'b0, `LSD_OFF_STAT, 32'h0);
		chk(n == 4'h0 ? rv[1] : rv[7:4], n == 4'h0 ? 4'h1 : n);
		wr(`LSD_OFF_STAT, 32'h2);
	endtask
	task automatic tend(input int t);
		$display("test %0d done", t);
	endtask
	initial begin
		logic [15:0] a;
		mclk = 0;
		rst_n = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		rd(pa(2), 32'h0);
		wr(pa(2), 32'h1234);
		wr(`LSD_OFF_OPND, 32'h0100);
		run(`LSD_OP_ST_HLMN, 13);
		chk(u_mem.mem[16'h0100], 8'h34);
		chk(u_mem.mem[16'h0101], 8'h12);
		u_mem.mem[16'h0200] = 8'hcd;
		u_mem.mem[16'h0201] = 8'hab;
		wr(`LSD_OFF_OPND, 32'h0200);
		run(`LSD_OP_LD_HLMN, 11);
		rd(pa(2), 32'habcd);
		u_mem.mem[16'h0200] = 8'h11;
		run(32'(`LSD_OP_LD_HLMN) | 32'h200, 11);
		rd(pa(6), 32'hab11);
		rd(pa(2), 32'habcd);
		tend(1);
		for (int f = 0; f < 4; f++) begin
			a = 16'(16'h0300 + 2 * f);
			u_mem.mem[a] = 8'(f + 1);
			u_mem.mem[a + 16'h1] = 8'(8'ha0 + f);
			wr(`LSD_OFF_OPND, 32'(a));
			run(32'(`LSD_OP_LD_DDMN) | (f << 7), 13);
			rd(pa(DMAP[f]), {16'h0, 8'(8'ha0 + f), 8'(f + 1)});
			wr(`LSD_OFF_OPND, 32'(a + 16'h40));
			run(32'(`LSD_OP_ST_SSMN) | (f << 7), 15);
			chk(u_mem.mem[a + 16'h40], 8'(f + 1));
			chk(u_mem.mem[a + 16'h41], 8'(8'ha0 + f));
		end
		for (int s = 0; s < 2; s++) begin
			a = 16'(16'h0500 + 2 * s);
			u_mem.mem[a] = 8'(8'h3c + s);
			u_mem.mem[a + 16'h1] = 8'h96;
			wr(`LSD_OFF_OPND, 32'(a));
			run(32'(`LSD_OP_LD_IDXMN) | (s << 12), 13);
			rd(pa(8 + s), {16'h0, 8'h96, 8'(8'h3c + s)});
			wr(`LSD_OFF_OPND, 32'(a + 16'h10));
			run(32'(`LSD_OP_ST_IDXMN) | (s << 12), 15);
			chk(u_mem.mem[a + 16'h10], 8'(8'h3c + s));
			chk(u_mem.mem[a + 16'h11], 8'h96);
		end
		tend(2);
		wr(pa(0), 32'h0102);
		wr(pa(1), 32'h0304);
		wr(pa(2), 32'h0700);
		wr(pa(3), 32'h05c5);
		// code 110 must leave the byte written by L untouched
		for (int f = 0; f < 8; f++) begin
			run(32'(`LSD_OP_ST_RHL) | (f << 4), f == 6 ? 4'h0 : 4'h6);
			chk(u_mem.mem[16'h0700], BYTES[f]);
		end
		rd(pa(3), 32'h05c5);
		tend(3);
		for (int f = 0; f < 8; f++) begin
			run(32'(`LSD_OP_LDALT) | (f << 4) | ((f % 3) << 7), 4);
			apb(1'b0, `LSD_OFF_COND, 32'h0);
			chk(rv[15:8], 8'h01 << f);
			if (VEC[f] != 16'h0)
				chk(rv[31:16], VEC[f]);
			rd(pa(4 + f % 3), 32'h0102);
		end
		tend(4);
		for (int p = 0; p < 2; p++) begin
			wr(pa(2), 32'h0700);
			wr(`LSD_OFF_OPND, 32'h0600);
			run(32'(`LSD_OP_ST_HLMN) | (1 << (10 + p)), 13);
			chk(u_mem.lastIo, {p[1:0] + 2'h1, 16'h0601, 8'h07});
			chk(u_mem.mem[16'h0601], 8'h00);
			run(32'(`LSD_OP_LD_HLMN) | (1 << (10 + p)), 11);
			rd(pa(2), 32'h0100);
		end
		wr(pa(11), 32'h1000);
		wr(`LSD_OFF_OPND, 32'h00fe0000);
		run(32'(`LSD_OP_JR) | (1 << 7), 5);
		rd(pa(11), 32'h0ffe);
		run(32'(`LSD_OP_RST) | (2 << 4), 8);
		rd(pa(11), 32'h0020);
		wr(pa(10), 32'h0800);
		run(32'(`LSD_OP_PUSH) | (1 << 7), 10);
		chk(u_mem.mem[16'h07ff], 8'h03);
		chk(u_mem.mem[16'h07fe], 8'h04);
		run(32'(`LSD_OP_POP), 7);
		rd(pa(0), 32'h0304);
		rd(pa(10), 32'h0800);
		run(32'(`LSD_OP_ADDIX) | (1 << 7), 4);
		rd(pa(8), 32'h9940);
		run(32'(`LSD_OP_ADDIX) | (1 << 7) | (1 << 12), 4);
		rd(pa(9), 32'h9941);
		tend(5);
		apb(1'b0, 12'h040, 32'h0);
		chk(ev, 1'b1);
		apb(1'b0, 12'h002, 32'h0);
		chk(ev, 1'b1);
		wr(`LSD_OFF_OPND, 32'h0200);
		wr(`LSD_OFF_CMD, `LSD_OP_LD_HLMN);
		apb(1'b1, `LSD_OFF_CMD, `LSD_OP_ST_HLMN);
		chk(ev, 1'b1);
		repeat (16) @(posedge mclk);
		tend(6);
		final_report;
	end
endmodule // lsd_load_store_tb
`default_nettype wire

// file: dv/lsd_mem_model.sv
/*
 * Behavioural program/data memory and io space behind the decoder.
 * Assumes one byte per memReq, read data wanted in the next cycle.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lsd_map.vh"
module lsd_mem_model (
	input wire logic        mclk,
	input wire logic        memReq,
	input wire logic        memWrite,
	input wire logic [15:0] memAddr,
	input wire logic [7:0]  memWdata,
	input wire logic [1:0]  memSpace,
	output var logic [7:0]  memRdata
);
	logic [7:0]  mem [0:65535];
	logic [25:0] lastIo;
	initial begin
		memRdata = 8'h00;
		lastIo = 26'h0;
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h00;
	end
	// io devices answer with the low address byte so io reads differ from memory
	always @(posedge mclk) begin
		if (memReq && memSpace != `LSD_SPACE_MEM) begin
			if (memWrite)
				lastIo <= {memSpace, memAddr, memWdata};
			memRdata <= memAddr[7:0];
		end else if (memReq) begin
			if (memWrite)
				mem[memAddr] <= memWdata;
			memRdata <= mem[memAddr];
		end else
			memRdata <= ~memRdata;
	end
endmodule // lsd_mem_model
`default_nettype wire

// file: dv/lsd_props.sv
/*
 * Port checker of the load/store decoder: APB answer timing, refusals,
 * busy window length and memory strobe order.
 * Assumes the single clock mclk and the asynchronous active-low rst_n.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lsd_map.vh"
module lsd_props (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        memReq,
	input wire logic        memWrite,
	input wire logic [15:0] memAddr,
	input wire logic [7:0]  memWdata,
	input wire logic [1:0]  memSpace,
	input wire logic [7:0]  memRdata,
	input wire logic        busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [4:0] runLen;
	wire        cmdWr = pready && pwrite && paddr == `LSD_OFF_CMD;
	// length of the current busy window, read when busy falls
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			runLen <= 5'h00;
		else
			runLen <= busy ? runLen + 5'h01 : 5'h00;
	end
	chk_ready_after_setup: assert property (psel && !penable |=> pready && penable)
		else $error("no ready in access phase");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	chk_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data outside access");
	chk_addr_refused: assert property (pready && (paddr > `LSD_OFF_PAIR_END ||
		paddr[1:0] != 2'h0) |-> pslverr)
		else $error("bad address not refused");
	chk_busy_lock: assert property (busy && cmdWr |-> pslverr)
		else $error("command taken while busy");
	chk_busy_cause: assert property ($rose(busy) |-> $past(cmdWr && !pslverr))
		else $error("busy without command");
	chk_req_inside: assert property (memReq |-> busy && memSpace != 2'h3)
		else $error("memory access outside instruction");
	chk_byte_order: assert property (memReq && $past(memReq) |->
		memAddr == $past(memAddr) + 16'h1 || memAddr == $past(memAddr) - 16'h1)
		else $error("second byte not adjacent");
	chk_busy_len: assert property ($fell(busy) |->
		runLen inside {4, 5, 6, 7, 8, 9, 10, 11, 13, 15})
		else $error("instruction length off table");
	cover property ($fell(busy) && runLen == 5'd15);
	cover property (memReq && memWrite && memSpace == `LSD_SPACE_INT);
	cover property (pready && pslverr);
endmodule // lsd_props
bind lsd_load_store lsd_props u_props (.mclk(mclk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
	.memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
	.memSpace(memSpace), .memRdata(memRdata), .busy(busy));
`default_nettype wire

// file: hdl/lsd_load_store.v
/*
 * Load/store decoder of an 8-bit core: decodes operand fields, runs immediate
 * and pointer based loads and stores, branches, restarts, push and pop.
 * Assumes an APB master on mclk and a synchronous memory that returns read
 * data in the cycle after memReq, with no wait states.
 */
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "lsd_map.vh"

// How it works
// - bit field value picks bit number directly
// - two-bit condition: not zero, zero, no carry, carry
// - signed displacement added to index register
// - destination field: first, second, pointer, stack
// - alternate field: alternate first, second, pointer
// - signed branch offset added to program counter
// - three-bit condition adds LV flag and sign tests
// - nibble set if any upper bit one
// - byte field B C D E H L, A
// - source field maps like destination field
// - restart field maps to fixed vectors
// - first index add field: first, second, index, stack
// - second index add field: first, second, index, stack
// - push/pop field: first, second, pointer, accumulator
// - store pointer pair low first, 13 clocks
// - load pointer pair low first, 11 clocks
// - store index word low first, 15 clocks
// - store source word low first, 15 clocks
// - load destination word low first, 13 clocks
// - load index word low first, 13 clocks
// - alternate prefix redirects affected destination register
// - io prefixes redirect affected stores to io
// - io prefixes redirect affected loads to io
module lsd_load_store (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         memReq,
	output reg         memWrite,
	output reg  [15:0] memAddr,
	output reg  [7:0]  memWdata,
	output reg  [1:0]  memSpace,
	input  wire [7:0]  memRdata,
	output reg         busy
);

	function [3:0] wordIdx;	// kind 0 dd/ss, 1 xx, 2 yy, 3 zz
		input [1:0] f;
		input [1:0] kind;
		begin
			case (f)
			2'b00: wordIdx = 4'h0;
			2'b01: wordIdx = 4'h1;
			2'b10: wordIdx = (kind == 2'd1) ? `LSD_IDX_XW1 :
				(kind == 2'd2) ? `LSD_IDX_XW2 : `LSD_IDX_PTR;
			default: wordIdx = (kind == 2'd3) ? `LSD_IDX_ACCF : `LSD_IDX_STK;
			endcase
		end
	endfunction

	function [3:0] bytePair;
		input [2:0] r;
		begin
			bytePair = (r == 3'b111) ? `LSD_IDX_ACCF : {2'b00, r[2:1]};
		end
	endfunction

	function byteHi;
		input [2:0] r;
		begin
			byteHi = (r == 3'b111) ? 1'b1 : ~r[0];
		end
	endfunction

	function [3:0] clkOf;
		input [3:0] op;
		begin
			case (op)
			`LSD_OP_ST_HLMN:  clkOf = `LSD_CLK_ST_HLMN;
			`LSD_OP_LD_HLMN:  clkOf = `LSD_CLK_LD_HLMN;
			`LSD_OP_ST_IDXMN: clkOf = `LSD_CLK_ST_IDXMN;
			`LSD_OP_ST_SSMN:  clkOf = `LSD_CLK_ST_SSMN;
			`LSD_OP_LD_DDMN:  clkOf = `LSD_CLK_LD_DDMN;
			`LSD_OP_LD_IDXMN: clkOf = `LSD_CLK_LD_IDXMN;
			`LSD_OP_ST_RHL:   clkOf = `LSD_CLK_ST_RHL;
			`LSD_OP_LD_RIXD:  clkOf = `LSD_CLK_LD_RIXD;
			`LSD_OP_JR:       clkOf = `LSD_CLK_JR;
			`LSD_OP_JP:       clkOf = `LSD_CLK_JP;
			`LSD_OP_RST:      clkOf = `LSD_CLK_RST;
			`LSD_OP_PUSH:     clkOf = `LSD_CLK_PUSH;
			`LSD_OP_POP:      clkOf = `LSD_CLK_POP;
			default:          clkOf = `LSD_CLK_SHORT;
			endcase
		end
	endfunction

	function badCmd;
		input [15:0] c;
		begin
			case (c[`LSD_F_OP])
			`LSD_OP_ST_RHL, `LSD_OP_LD_RIXD, `LSD_OP_SETB:
				badCmd = (c[`LSD_F_FLD3] == 3'b110);
			`LSD_OP_RST:
				badCmd = (c[`LSD_F_FLD3] == 3'b000) || (c[`LSD_F_FLD3] == 3'b001) ||
					(c[`LSD_F_FLD3] == 3'b110);
			`LSD_OP_LDALT:
				badCmd = (c[`LSD_F_FLD2] == 2'b11);
			default:
				badCmd = 1'b0;
			endcase
		end
	endfunction

	reg  [15:0] cmd;
	reg  [23:0] opnd;
	reg  [3:0]  cnt;
	reg  [3:0]  total;
	reg  [7:0]  rdLo;
	reg  [7:0]  rdHi;
	reg         illegal;
	reg         taken;
	reg         wrAEn;
	reg  [3:0]  wrAIdx;
	reg  [15:0] wrAData;
	reg         wrBEn;
	reg  [3:0]  wrBIdx;
	reg  [15:0] wrBData;
	reg  [15:0] addrA;
	reg  [7:0]  firstByte;
	reg  [7:0]  secondByte;
	reg  [15:0] vector;
	reg         cond3;
	reg  [31:0] rdMux;
	wire [15:0] pairs [0:11];

	wire [3:0]  op      = cmd[`LSD_F_OP];
	wire [2:0]  f3      = cmd[`LSD_F_FLD3];
	wire [1:0]  f2      = cmd[`LSD_F_FLD2];
	wire        alternate_select_prefix    = cmd[`LSD_B_ALTSEL];
	wire        idxSel  = cmd[`LSD_B_IDXSEL];
	wire [15:0] mn      = opnd[`LSD_F_MN];
	wire [7:0]  nByte   = opnd[`LSD_F_BYTE];
	wire [15:0] sExt    = {{8{nByte[7]}}, nByte};
	wire [7:0]  flags   = pairs[`LSD_IDX_ACCF][7:0];
	wire [15:0] stkWord = pairs[`LSD_IDX_STK];
	wire [15:0] idxWord = idxSel ? pairs[`LSD_IDX_XW2] : pairs[`LSD_IDX_XW1];
	wire [3:0]  rPair   = bytePair(f3);
	wire        rHi     = byteHi(f3);
	wire [7:0]  rByte   = rHi ? pairs[rPair][15:8] : pairs[rPair][7:0];
	wire [7:0]  bitMask = 8'h01 << f3;
	wire [3:0]  altPair = (alternate_select_prefix && rPair < 4'h4) ? rPair + 4'h4 : rPair;
	wire [15:0] altOld  = pairs[altPair];
	wire [3:0]  ddIdx   = wordIdx(f2, 2'd0);
	wire [3:0]  zzIdx   = wordIdx(f2, 2'd3);
	wire [3:0]  addIdx  = wordIdx(f2, idxSel ? 2'd2 : 2'd1);
	wire [16:0] addSum  = {1'b0, idxWord} + {1'b0, pairs[addIdx]};
	wire        isPush  = (op == `LSD_OP_PUSH);
	wire        isPop   = (op == `LSD_OP_POP);
	wire        isStore = (op == `LSD_OP_ST_HLMN) || (op == `LSD_OP_ST_IDXMN) ||
		(op == `LSD_OP_ST_SSMN) || (op == `LSD_OP_ST_RHL) || isPush;
	wire        isLoad  = (op == `LSD_OP_LD_HLMN) || (op == `LSD_OP_LD_DDMN) ||
		(op == `LSD_OP_LD_IDXMN) || (op == `LSD_OP_LD_RIXD) || isPop;
	wire        oneByte = (op == `LSD_OP_ST_RHL) || (op == `LSD_OP_LD_RIXD);
	wire [15:0] addrB   = isPush ? stkWord - 16'h0002 : addrA + 16'h0001;
	wire        cond2   = f2[1] ? (flags[`LSD_FLAG_C] == f2[0]) :
		(flags[`LSD_FLAG_Z] == f2[0]);
	wire        nibSet  = |nByte[7:4];
	wire [1:0]  space   = (isPush || isPop) ? `LSD_SPACE_MEM :
		cmd[`LSD_B_IOI] ? `LSD_SPACE_INT :
		cmd[`LSD_B_IOEXT] ? `LSD_SPACE_EXT : `LSD_SPACE_MEM;
	wire        lastCyc = busy && (cnt == total);

	wire        apbSetup = psel && !penable;
	wire        apbDone  = psel && penable && pready;
	wire        inPair   = (paddr >= `LSD_OFF_PAIR) && (paddr <= `LSD_OFF_PAIR_END);
	wire        mapped   = (paddr[1:0] == 2'b00) && (inPair || paddr < `LSD_OFF_PAIR);
	wire        errNext  = !mapped || (pwrite && busy && (inPair ||
		paddr == `LSD_OFF_CMD || paddr == `LSD_OFF_OPND));
	wire        wrOk     = apbDone && pwrite && !pslverr;
	wire        cmdWr    = wrOk && (paddr == `LSD_OFF_CMD);
	wire        cmdBad   = badCmd(pwdata[15:0]);
	wire [3:0]  apbIdx   = paddr[5:2] - 4'h4;

	always @* begin
		case (f3)
		3'b000:  cond3 = !flags[`LSD_FLAG_Z];
		3'b001:  cond3 = flags[`LSD_FLAG_Z];
		3'b010:  cond3 = !flags[`LSD_FLAG_C];
		3'b011:  cond3 = flags[`LSD_FLAG_C];
		3'b100:  cond3 = !flags[`LSD_FLAG_LV];
		3'b101:  cond3 = flags[`LSD_FLAG_LV];
		3'b110:  cond3 = !flags[`LSD_FLAG_S];
		default: cond3 = flags[`LSD_FLAG_S];
		endcase
		case (f3)
		3'b010:  vector = 16'h0020;
		3'b011:  vector = 16'h0030;
		3'b100:  vector = 16'h0040;
		3'b101:  vector = 16'h0050;
		default: vector = 16'h0070;
		endcase
	end

	// first and second byte of each access; multi-byte memory order is low then high, except push which writes high first
	always @* begin
		addrA = mn;
		firstByte = 8'h00;
		secondByte = 8'h00;
		case (op)
		`LSD_OP_ST_HLMN: begin
			firstByte = pairs[`LSD_IDX_PTR][7:0];
			secondByte = pairs[`LSD_IDX_PTR][15:8];
		end
		`LSD_OP_ST_IDXMN: begin
			firstByte = idxWord[7:0];
			secondByte = idxWord[15:8];
		end
		`LSD_OP_ST_SSMN: begin
			firstByte = pairs[ddIdx][7:0];
			secondByte = pairs[ddIdx][15:8];
		end
		`LSD_OP_ST_RHL: begin
			addrA = pairs[`LSD_IDX_PTR];
			firstByte = rByte;
		end
		`LSD_OP_LD_RIXD: begin
			addrA = idxWord + sExt;
		end
		`LSD_OP_PUSH: begin
			addrA = stkWord - 16'h0001;	// high byte sits above low byte on the stack
			firstByte = pairs[zzIdx][15:8];
			secondByte = pairs[zzIdx][7:0];
		end
		`LSD_OP_POP: begin
			addrA = stkWord;
		end
		default: begin
			addrA = mn;
		end
		endcase
	end

	// writeback on the final cycle; flags are touched only by the index add and by pop of the accumulator pair
	always @* begin
		wrAEn = 1'b0;
		wrAIdx = 4'h0;
		wrAData = 16'h0000;
		wrBEn = 1'b0;
		wrBIdx = 4'h0;
		wrBData = 16'h0000;
		if (lastCyc) begin
			case (op)
			`LSD_OP_LD_HLMN: begin
				wrAEn = 1'b1;
				wrAIdx = alternate_select_prefix ? `LSD_IDX_PTR + 4'h4 : `LSD_IDX_PTR;
				wrAData = {rdHi, rdLo};
			end
			`LSD_OP_LD_DDMN: begin
				wrAEn = 1'b1;
				wrAIdx = (alternate_select_prefix && ddIdx < 4'h4) ? ddIdx + 4'h4 : ddIdx;
				wrAData = {rdHi, rdLo};
			end
			`LSD_OP_LD_IDXMN: begin
				wrAEn = 1'b1;
				wrAIdx = idxSel ? `LSD_IDX_XW2 : `LSD_IDX_XW1;
				wrAData = {rdHi, rdLo};
			end
			`LSD_OP_LD_RIXD, `LSD_OP_SETB: begin
				wrAEn = 1'b1;
				wrAIdx = altPair;
				if (op == `LSD_OP_SETB) begin
					wrAData = rHi ? {rByte | bitMask, altOld[7:0]} :
						{altOld[15:8], rByte | bitMask};
				end else begin
					wrAData = rHi ? {rdLo, altOld[7:0]} : {altOld[15:8], rdLo};
				end
			end
			`LSD_OP_JR: begin
				wrAEn = cond2;
				wrAIdx = `LSD_IDX_PGM;
				wrAData = pairs[`LSD_IDX_PGM] + sExt;
			end
			`LSD_OP_JP: begin
				wrAEn = cond3;
				wrAIdx = `LSD_IDX_PGM;
				wrAData = mn;
			end
			`LSD_OP_RST: begin
				wrAEn = 1'b1;
				wrAIdx = `LSD_IDX_PGM;
				wrAData = vector;
			end
			`LSD_OP_PUSH: begin
				wrBEn = 1'b1;
				wrBIdx = `LSD_IDX_STK;
				wrBData = stkWord - 16'h0002;
			end
			`LSD_OP_POP: begin
				wrAEn = 1'b1;
				wrAIdx = (alternate_select_prefix && zzIdx < 4'h4) ? zzIdx + 4'h4 : zzIdx;
				wrAData = {rdHi, rdLo};
				wrBEn = 1'b1;
				wrBIdx = `LSD_IDX_STK;
				wrBData = stkWord + 16'h0002;
			end
			`LSD_OP_ADDIX: begin
				wrAEn = 1'b1;
				wrAIdx = idxSel ? `LSD_IDX_XW2 : `LSD_IDX_XW1;
				wrAData = addSum[15:0];
				wrBEn = 1'b1;
				wrBIdx = `LSD_IDX_ACCF;
				wrBData = {pairs[`LSD_IDX_ACCF][15:1], addSum[16]};
			end
			`LSD_OP_LDALT: begin
				wrAEn = 1'b1;
				wrAIdx = {2'b01, f2};
				wrAData = idxSel ? pairs[4'h1] : pairs[4'h0];
			end
			default: begin
				wrAEn = 1'b0;	// stores other than push change no register
			end
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 12; gi = gi + 1) begin : g_pair
			reg [15:0] word;
			always @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					word <= `LSD_PAIR_RST;
				end else if (wrAEn && wrAIdx == gi) begin
					word <= wrAData;
				end else if (wrBEn && wrBIdx == gi) begin
					word <= wrBData;
				end else if (wrOk && inPair && apbIdx == gi) begin
					word <= pwdata[15:0];
				end
			end
			assign pairs[gi] = word;
		end
	endgenerate

	always @* begin
		rdMux = 32'h0000_0000;
		if (inPair) begin
			rdMux = {16'h0000, pairs[apbIdx]};
		end else begin
			case (paddr)
			`LSD_OFF_CMD:  rdMux = {16'h0000, cmd};
			`LSD_OFF_OPND: rdMux = {8'h00, opnd};
			`LSD_OFF_STAT: rdMux = {24'h00_0000, total, 1'b0, taken, illegal, busy};
			`LSD_OFF_COND: rdMux = {vector, bitMask, 4'h0, !nibSet, nibSet, cond3, cond2};
			default:       rdMux = 32'h0000_0000;
			endcase
		end
	end

	// zero wait states: pready rises in every access phase
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apbSetup;
			pslverr <= apbSetup && errNext;
			prdata <= (apbSetup && !pwrite && mapped) ? rdMux : 32'h0000_0000;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmd <= 16'h0000;
			opnd <= 24'h00_0000;
			cnt <= 4'h0;
			total <= 4'h0;
			busy <= 1'b0;
			illegal <= 1'b0;
			taken <= 1'b0;
			rdLo <= 8'h00;
			rdHi <= 8'h00;
			memReq <= 1'b0;
			memWrite <= 1'b0;
			memAddr <= 16'h0000;
			memWdata <= 8'h00;
			memSpace <= `LSD_SPACE_MEM;
		end else begin
			memReq <= 1'b0;
			memWrite <= 1'b0;
			if (wrOk && paddr == `LSD_OFF_OPND) begin
				opnd <= pwdata[23:0];
			end
			// a refused command sets the sticky flag even while software clears it
			if (cmdWr && cmdBad) begin
				illegal <= 1'b1;
			end else if (wrOk && paddr == `LSD_OFF_STAT && pwdata[`LSD_STAT_CLEAR_BIT]) begin
				illegal <= 1'b0;
			end
			if (busy) begin
				cnt <= cnt + 4'h1;
				if ((isStore || isLoad) && (cnt == 4'h1 || (cnt == 4'h2 && !oneByte))) begin
					memReq <= 1'b1;
					memWrite <= isStore;
					memAddr <= (cnt == 4'h1) ? addrA : addrB;
					memWdata <= (cnt == 4'h1) ? firstByte : secondByte;
					memSpace <= space;
				end
				if (cnt == 4'h3) begin
					rdLo <= memRdata;
				end
				if (cnt == 4'h4) begin
					rdHi <= memRdata;
				end
				if (lastCyc) begin
					busy <= 1'b0;
					taken <= wrAEn && wrAIdx == `LSD_IDX_PGM;
				end
			end else if (cmdWr && !cmdBad) begin
				cmd <= pwdata[15:0];
				total <= clkOf(pwdata[3:0]);
				cnt <= 4'h1;
				busy <= 1'b1;
			end
		end
	end

endmodule // lsd_load_store
`default_nettype wire

// file: hdl/lsd_map.vh
/*
 * Constants for the load/store decoder: register offsets, command field
 * positions, opcode numbers, clock counts per operation and flag bit positions.
 * Assumes it is included by bare name from the design file.
 */
`ifndef LSD_MAP_VH
`define LSD_MAP_VH

`define LSD_OFF_CMD       12'h000
`define LSD_OFF_OPND      12'h004
`define LSD_OFF_STAT      12'h008
`define LSD_OFF_COND      12'h00c
`define LSD_OFF_PAIR      12'h010
`define LSD_OFF_PAIR_END  12'h03c

`define LSD_F_OP      3:0
`define LSD_F_FLD3    6:4
`define LSD_F_FLD2    8:7
`define LSD_B_ALTSEL  9
`define LSD_B_IOI     10
`define LSD_B_IOEXT   11
`define LSD_B_IDXSEL  12
`define LSD_F_MN      15:0
`define LSD_F_BYTE    23:16
`define LSD_STAT_CLEAR_BIT 1

`define LSD_OP_ST_HLMN   4'h0
`define LSD_OP_LD_HLMN   4'h1
`define LSD_OP_ST_IDXMN  4'h2
`define LSD_OP_ST_SSMN   4'h3
`define LSD_OP_LD_DDMN   4'h4
`define LSD_OP_LD_IDXMN  4'h5
`define LSD_OP_ST_RHL    4'h6
`define LSD_OP_LD_RIXD   4'h7
`define LSD_OP_JR        4'h8
`define LSD_OP_JP        4'h9
`define LSD_OP_RST       4'ha
`define LSD_OP_PUSH      4'hb
`define LSD_OP_POP       4'hc
`define LSD_OP_SETB      4'hd
`define LSD_OP_ADDIX     4'he
`define LSD_OP_LDALT     4'hf

`define LSD_CLK_ST_HLMN  4'hd
`define LSD_CLK_LD_HLMN  4'hb
`define LSD_CLK_ST_IDXMN 4'hf
`define LSD_CLK_ST_SSMN  4'hf
`define LSD_CLK_LD_DDMN  4'hd
`define LSD_CLK_LD_IDXMN 4'hd
`define LSD_CLK_ST_RHL   4'h6
`define LSD_CLK_LD_RIXD  4'h9
`define LSD_CLK_JR       4'h5
`define LSD_CLK_JP       4'h7
`define LSD_CLK_RST      4'h8
`define LSD_CLK_PUSH     4'ha
`define LSD_CLK_POP      4'h7
`define LSD_CLK_SHORT    4'h4

`define LSD_IDX_PTR  4'h2
`define LSD_IDX_ACCF 4'h3
`define LSD_IDX_XW1  4'h8
`define LSD_IDX_XW2  4'h9
`define LSD_IDX_STK  4'ha
`define LSD_IDX_PGM  4'hb
`define LSD_PAIR_RST 16'h0000

`define LSD_FLAG_S   7
`define LSD_FLAG_Z   6
`define LSD_FLAG_LV  2
`define LSD_FLAG_C   0

`define LSD_SPACE_MEM 2'h0
`define LSD_SPACE_INT 2'h1
`define LSD_SPACE_EXT 2'h2

`endif
